// ==== mcsr_defines.vh ====
// constants for the core special-function register block
`ifndef MCSR_DEFINES_VH
`define MCSR_DEFINES_VH
// special addresses
`define MCSR_ADDR_STACK 8'h81
`define MCSR_ADDR_P0_LO 8'h82
`define MCSR_ADDR_P0_HI 8'h83
`define MCSR_ADDR_P1_LO 8'h84
`define MCSR_ADDR_P1_HI 8'h85
`define MCSR_ADDR_TIMING 8'h8e
`define MCSR_ADDR_PCHOICE 8'h92
`define MCSR_ADDR_FLAGS 8'hd0
`define MCSR_ADDR_ACC 8'he0
`define MCSR_ADDR_HELPER 8'hf0
// reset values
`define MCSR_RST_STACK 8'h07
`define MCSR_RST_PTR 8'h00
`define MCSR_RST_TIMING_WAIT 3'h0
`define MCSR_RST_TIMING_STRETCH 3'h1
`define MCSR_RST_PCHOICE 1'h0
`define MCSR_RST_FLAGS 8'h00
`define MCSR_RST_ACC 8'h00
`define MCSR_RST_HELPER 8'h00
// flags word bit positions
`define MCSR_FLAG_CARRY 7
`define MCSR_FLAG_HALF 6
`define MCSR_FLAG_USER0 5
`define MCSR_FLAG_BANK_HI 4
`define MCSR_FLAG_BANK_LO 3
`define MCSR_FLAG_OFLOW 2
`define MCSR_FLAG_USER1 1
`define MCSR_FLAG_PARITY 0
// timing register fields
`define MCSR_WAIT_HI 6
`define MCSR_WAIT_LO 4
`define MCSR_STRETCH_HI 2
`define MCSR_STRETCH_LO 0
// pointer choice bit
`define MCSR_PCHOICE_BIT 0
// memory map
`define MCSR_INTERNAL_SCRATCH_RAM_AW 8
`define MCSR_XRAM_AW 11
`define MCSR_XRAM_BASE 16'h8000
`define MCSR_XRAM_LAST 16'h87ff
`endif

// ==== mcsr_ram.v ====
// single-port synchronous byte ram with registered read
`timescale 1ns/1ns
module mcsr_ram #(
  parameter AW = 8
) (
  // clock and reset
  input wire core_clk_i,
  input wire reset_i,
  // access port
  input wire wr_i,
  input wire rd_i,
  input wire [AW-1:0] addr_i,
  input wire [7:0] wdata_i,
  output wire [7:0] rdata_o
);
  // storage, no reset: contents are undefined at power-up
  reg [7:0] mem [0:(1<<AW)-1];
  reg [7:0] rdata;
  // write port
  always @(posedge core_clk_i) begin
    if (wr_i) begin
      mem[addr_i] <= wdata_i;
    end
  end
  // read data stands for one cycle only, zero otherwise
  always @(posedge core_clk_i) begin
    if (reset_i) begin
      rdata <= 8'h00;
    end else if (rd_i) begin
      rdata <= mem[addr_i];
    end else begin
      rdata <= 8'h00;
    end
  end
  assign rdata_o = rdata;
endmodule // mcsr_ram

// ==== mcsr_core_regs.v ====
// core special-function registers, internal and external ram of the mcu
// Function
// - helper byte at 0xf0, resets zero
// - flags bit 7 is carry, boolean accumulator
// - flags bit 6 set on bit-3 carry
// - flags bits 4-3 pick one of four banks
// - flags bit 2 set on signed overflow
// - flags bit 0 is odd accumulator parity
// - software cannot write parity bit
// - bits 5 and 1 are software-only flags
// - stack pre-increments on push, post-decrements on pop
// - each pointer is sixteen bits, two bytes
// - pointer loads whole or per byte, increments whole only
// - two pointers, selected one serves instructions
// - choice bit 0 picks pointer, rest unused
// - 256-byte internal ram, upper half indirect only
// - 2048-byte ram at 0x8000 to 0x87ff
// - timing bits 6-4 wait states, reset 000
// - timing bits 2-0 stretch, reset 001
// - accumulator at 0xe0, resets zero, drives parity
//
// Chosen here: strobed register access.
`timescale 1ns/1ns
`include "mcsr_defines.vh"
module mcsr_core_regs (
  // clock and reset
  input wire core_clk_i,
  input wire reset_i,
  // software register port
  input wire [7:0] sfr_addr_i,
  input wire [7:0] sfr_wdata_i,
  input wire sfr_wr_i,
  input wire sfr_rd_i,
  output wire [7:0] sfr_rdata_o,
  // accumulator and flag updates from the execution unit
  input wire acc_we_i,
  input wire [7:0] acc_i,
  input wire carry_we_i,
  input wire carry_i,
  input wire arith_we_i,
  input wire half_carry_i,
  input wire arith_oflow_i,
  // helper byte update from multiply and divide
  input wire helper_we_i,
  input wire [7:0] helper_i,
  // stack moves
  input wire stack_push_i,
  input wire stack_pop_i,
  // selected pointer commands
  input wire ptr_load_i,
  input wire [15:0] ptr_load_value_i,
  input wire ptr_inc_i,
  // working register number within the active bank
  input wire [2:0] work_reg_i,
  // internal ram port
  input wire [7:0] internal_scratch_ram_addr_i,
  input wire internal_scratch_ram_indirect_i,
  input wire internal_scratch_ram_wr_i,
  input wire internal_scratch_ram_rd_i,
  input wire [7:0] internal_scratch_ram_wdata_i,
  output wire [7:0] internal_scratch_ram_rdata_o,
  output wire internal_scratch_ram_refused_o,
  // external data space port
  input wire [15:0] xram_addr_i,
  input wire xram_wr_i,
  input wire xram_rd_i,
  input wire [7:0] xram_wdata_i,
  output wire [7:0] xram_rdata_o,
  output wire xram_hit_o,
  // register state toward the core
  output wire [7:0] acc_o,
  output wire [7:0] helper_o,
  output wire [7:0] flags_o,
  output wire [7:0] stack_top_o,
  output wire [15:0] ptr_addr_o,
  output wire [7:0] work_reg_addr_o,
  output wire [2:0] prog_wait_states_o,
  output wire [2:0] external_space_ram_stretch_o
);

  // internal ram reachability: upper half needs indirect mode
  function internal_scratch_ram_reachable;
    input [7:0] addr;
    input indirect;
    begin
      internal_scratch_ram_reachable = indirect | ~addr[7];
    end
  endfunction

  // external ram window decode
  function xram_in_window;
    input [15:0] addr;
    begin
      xram_in_window = (addr >= `MCSR_XRAM_BASE) && (addr <= `MCSR_XRAM_LAST);
    end
  endfunction

  // register state
  reg [7:0] acc; // accumulator
  reg [7:0] helper; // multiply/divide helper byte
  reg carry_flag; // flags bit 7
  reg half_carry_flag; // flags bit 6
  reg user_flag_zero; // flags bit 5
  reg [1:0] bank_choice; // flags bits 4-3
  reg arith_oflow_flag; // flags bit 2
  reg user_flag_one; // flags bit 1
  reg [7:0] stack_top_pointer; // stack pointer
  reg [7:0] ptr_lo [0:1]; // pointer low bytes
  reg [7:0] ptr_hi [0:1]; // pointer high bytes
  reg pointer_choice; // active pointer index
  reg [2:0] wait_states; // timing bits 6-4
  reg [2:0] stretch; // timing bits 2-0
  reg [7:0] sfr_rdata; // registered read data

  // derived values
  wire parity_bit;
  wire [7:0] flags_word;
  wire [15:0] ptr_sel;
  wire [15:0] ptr_inc_value;
  wire [7:0] ptr_choice_read;
  wire [7:0] timing_read;
  reg [7:0] next_sfr_rdata;

  // software write strobes per register
  wire wr_acc;
  wire wr_helper;
  wire wr_flags;
  wire wr_stack;
  wire wr_choice;
  wire wr_timing;

  // ram gating
  wire internal_scratch_ram_ok;
  wire internal_scratch_ram_wr_ok;
  wire internal_scratch_ram_rd_ok;
  wire xram_ok;

  // address decode of software writes
  assign wr_acc = sfr_wr_i && (sfr_addr_i == `MCSR_ADDR_ACC);
  assign wr_helper = sfr_wr_i && (sfr_addr_i == `MCSR_ADDR_HELPER);
  assign wr_flags = sfr_wr_i && (sfr_addr_i == `MCSR_ADDR_FLAGS);
  assign wr_stack = sfr_wr_i && (sfr_addr_i == `MCSR_ADDR_STACK);
  assign wr_choice = sfr_wr_i && (sfr_addr_i == `MCSR_ADDR_PCHOICE);
  assign wr_timing = sfr_wr_i && (sfr_addr_i == `MCSR_ADDR_TIMING);

  // parity follows the accumulator register, never stored
  assign parity_bit = ^acc;

  // assembled flags word
  assign flags_word = {carry_flag, half_carry_flag, user_flag_zero,
                       bank_choice, arith_oflow_flag, user_flag_one,
                       parity_bit};

  // accumulator: execution unit wins over a software write
  always @(posedge core_clk_i) begin
    if (reset_i) begin
      acc <= `MCSR_RST_ACC;
    end else if (acc_we_i) begin
      acc <= acc_i;
    end else if (wr_acc) begin
      acc <= sfr_wdata_i;
    end
  end

  // helper byte: multiply/divide result beats software scratch write
  always @(posedge core_clk_i) begin
    if (reset_i) begin
      helper <= `MCSR_RST_HELPER;
    end else if (helper_we_i) begin
      helper <= helper_i;
    end else if (wr_helper) begin
      helper <= sfr_wdata_i;
    end
  end

  // carry: arithmetic and boolean results set it, hardware first
  always @(posedge core_clk_i) begin
    if (reset_i) begin
      carry_flag <= 1'b0; // whole flags word resets to zero
    end else if (carry_we_i) begin
      carry_flag <= carry_i;
    end else if (wr_flags) begin
      carry_flag <= sfr_wdata_i[`MCSR_FLAG_CARRY];
    end
  end

  // half carry and overflow from accumulator arithmetic
  always @(posedge core_clk_i) begin
    if (reset_i) begin
      half_carry_flag <= 1'b0;
      arith_oflow_flag <= 1'b0;
    end else if (arith_we_i) begin
      // hardware result wins over a same-cycle software write
      half_carry_flag <= half_carry_i;
      arith_oflow_flag <= arith_oflow_i;
    end else if (wr_flags) begin
      half_carry_flag <= sfr_wdata_i[`MCSR_FLAG_HALF];
      arith_oflow_flag <= sfr_wdata_i[`MCSR_FLAG_OFLOW];
    end
  end

  // user flags and bank choice: software only, hardware never touches
  always @(posedge core_clk_i) begin
    if (reset_i) begin
      user_flag_zero <= 1'b0;
      user_flag_one <= 1'b0;
      bank_choice <= 2'h0;
    end else if (wr_flags) begin
      user_flag_zero <= sfr_wdata_i[`MCSR_FLAG_USER0];
      user_flag_one <= sfr_wdata_i[`MCSR_FLAG_USER1];
      bank_choice <= sfr_wdata_i[`MCSR_FLAG_BANK_HI:`MCSR_FLAG_BANK_LO];
      // written parity bit is simply dropped here
    end
  end

  // working register address: bank times eight plus register number
  assign work_reg_addr_o = {3'h0, bank_choice, work_reg_i};

  // stack pointer: a lone push or pop wins over a software write
  always @(posedge core_clk_i) begin
    if (reset_i) begin
      stack_top_pointer <= `MCSR_RST_STACK;
    end else if (stack_push_i && !stack_pop_i) begin
      // bumped before the store; core stores at the new top next cycle
      stack_top_pointer <= stack_top_pointer + 8'h01;
    end else if (stack_pop_i && !stack_push_i) begin
      // core reads at the old top this cycle, then it drops
      stack_top_pointer <= stack_top_pointer - 8'h01;
    end else if (wr_stack) begin
      stack_top_pointer <= sfr_wdata_i;
    end
  end

  // selected pointer as one sixteen-bit value
  assign ptr_sel = {ptr_hi[pointer_choice], ptr_lo[pointer_choice]};
  assign ptr_inc_value = ptr_sel + 16'h0001;

  // one identical register pair per pointer
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_ptr
      // this pointer is the target of whole-pointer commands
      wire active;
      wire wr_lo;
      wire wr_hi;
      assign active = (pointer_choice == gi);
      assign wr_lo = sfr_wr_i &&
                     (sfr_addr_i == (gi == 0 ? `MCSR_ADDR_P0_LO : `MCSR_ADDR_P1_LO));
      assign wr_hi = sfr_wr_i &&
                     (sfr_addr_i == (gi == 0 ? `MCSR_ADDR_P0_HI : `MCSR_ADDR_P1_HI));
      // sixteen-bit command beats a byte write in the same cycle
      always @(posedge core_clk_i) begin
        if (reset_i) begin
          ptr_lo[gi] <= `MCSR_RST_PTR;
          ptr_hi[gi] <= `MCSR_RST_PTR;
        end else if (active && ptr_load_i) begin
          ptr_lo[gi] <= ptr_load_value_i[7:0];
          ptr_hi[gi] <= ptr_load_value_i[15:8];
        end else if (active && ptr_inc_i) begin
          ptr_lo[gi] <= ptr_inc_value[7:0];
          ptr_hi[gi] <= ptr_inc_value[15:8];
        end else begin
          // halves written independently
          if (wr_lo) begin
            ptr_lo[gi] <= sfr_wdata_i;
          end
          if (wr_hi) begin
            ptr_hi[gi] <= sfr_wdata_i;
          end
        end
      end
    end
  endgenerate

  // pointer choice: only bit 0 is stored
  always @(posedge core_clk_i) begin
    if (reset_i) begin
      pointer_choice <= `MCSR_RST_PCHOICE;
    end else if (wr_choice) begin
      pointer_choice <= sfr_wdata_i[`MCSR_PCHOICE_BIT];
    end
  end

  // memory timing fields; reserved codes are stored as written
  always @(posedge core_clk_i) begin
    if (reset_i) begin
      wait_states <= `MCSR_RST_TIMING_WAIT;
      stretch <= `MCSR_RST_TIMING_STRETCH;
    end else if (wr_timing) begin
      wait_states <= sfr_wdata_i[`MCSR_WAIT_HI:`MCSR_WAIT_LO];
      stretch <= sfr_wdata_i[`MCSR_STRETCH_HI:`MCSR_STRETCH_LO];
    end
  end

  // read views with unused bits forced low
  assign ptr_choice_read = {7'h00, pointer_choice};
  assign timing_read = {1'b0, wait_states, 1'b0, stretch};

  // read mux; unmapped addresses answer zero
  always @* begin
    next_sfr_rdata = 8'h00;
    case (sfr_addr_i)
      `MCSR_ADDR_ACC: next_sfr_rdata = acc;
      `MCSR_ADDR_HELPER: next_sfr_rdata = helper;
      `MCSR_ADDR_FLAGS: next_sfr_rdata = flags_word;
      `MCSR_ADDR_STACK: next_sfr_rdata = stack_top_pointer;
      `MCSR_ADDR_P0_LO: next_sfr_rdata = ptr_lo[0];
      `MCSR_ADDR_P0_HI: next_sfr_rdata = ptr_hi[0];
      `MCSR_ADDR_P1_LO: next_sfr_rdata = ptr_lo[1];
      `MCSR_ADDR_P1_HI: next_sfr_rdata = ptr_hi[1];
      `MCSR_ADDR_PCHOICE: next_sfr_rdata = ptr_choice_read;
      `MCSR_ADDR_TIMING: next_sfr_rdata = timing_read;
      default: next_sfr_rdata = 8'h00;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always @(posedge core_clk_i) begin
    if (reset_i) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd_i) begin
      sfr_rdata <= next_sfr_rdata;
    end else begin
      sfr_rdata <= 8'h00;
    end
  end

  // internal ram: direct access above 0x7f belongs to register space
  assign internal_scratch_ram_ok = internal_scratch_ram_reachable(internal_scratch_ram_addr_i, internal_scratch_ram_indirect_i);
  assign internal_scratch_ram_wr_ok = internal_scratch_ram_wr_i && internal_scratch_ram_ok;
  assign internal_scratch_ram_rd_ok = internal_scratch_ram_rd_i && internal_scratch_ram_ok;
  // refusal is a same-cycle handshake flag, no state kept
  assign internal_scratch_ram_refused_o = (internal_scratch_ram_wr_i || internal_scratch_ram_rd_i) && !internal_scratch_ram_ok;

  mcsr_ram #(
    .AW(`MCSR_INTERNAL_SCRATCH_RAM_AW)
  ) u_internal_scratch_ram (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .wr_i(internal_scratch_ram_wr_ok),
    .rd_i(internal_scratch_ram_rd_ok),
    .addr_i(internal_scratch_ram_addr_i),
    .wdata_i(internal_scratch_ram_wdata_i),
    .rdata_o(internal_scratch_ram_rdata_o)
  );

  // external ram only answers inside its fixed window
  assign xram_ok = xram_in_window(xram_addr_i);
  assign xram_hit_o = xram_ok;

  mcsr_ram #(
    .AW(`MCSR_XRAM_AW)
  ) u_external_space_ram (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .wr_i(xram_wr_i && xram_ok),
    .rd_i(xram_rd_i && xram_ok),
    .addr_i(xram_addr_i[`MCSR_XRAM_AW-1:0]),
    .wdata_i(xram_wdata_i),
    .rdata_o(xram_rdata_o)
  );

  // outputs from registers; parity bit and selected pointer pass through logic
  assign sfr_rdata_o = sfr_rdata;
  assign acc_o = acc;
  assign helper_o = helper;
  assign flags_o = flags_word;
  assign stack_top_o = stack_top_pointer;
  assign ptr_addr_o = ptr_sel;
  assign prog_wait_states_o = wait_states;
  assign external_space_ram_stretch_o = stretch;

endmodule // mcsr_core_regs

// ==== mcsr_core_regs_props.sv ====
// concurrent checks on the core register block ports
`timescale 1ns/1ns
module mcsr_core_regs_props (
  // clock and reset
  input wire core_clk_i,
  input wire reset_i,
  // watched inputs, grouped to keep the checker short
  input wire sfr_rd_i, sfr_wr_i, acc_we_i, carry_we_i, carry_i, arith_we_i,
  input wire half_carry_i, arith_oflow_i, helper_we_i, stack_push_i, stack_pop_i,
  input wire ptr_load_i, ptr_inc_i, internal_scratch_ram_indirect_i, internal_scratch_ram_wr_i, internal_scratch_ram_rd_i,
  input wire [7:0] acc_i, helper_i, internal_scratch_ram_addr_i,
  input wire [2:0] work_reg_i,
  input wire [15:0] xram_addr_i,
  // watched outputs
  input wire [7:0] sfr_rdata_o, acc_o, helper_o, flags_o, stack_top_o, work_reg_addr_o,
  input wire [15:0] ptr_addr_o,
  input wire internal_scratch_ram_refused_o, xram_hit_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  // parity must follow the accumulator in the same cycle
  property p_parity; flags_o[0] == ^acc_o; endproperty
  a_parity: assert property (p_parity) else $error("parity bit off");
  property p_acc; acc_we_i |=> acc_o == $past(acc_i); endproperty
  a_acc: assert property (p_acc) else $error("accumulator load lost");
  property p_helper; helper_we_i |=> helper_o == $past(helper_i); endproperty
  a_helper: assert property (p_helper) else $error("helper load lost");
  property p_carry; carry_we_i |=> flags_o[7] == $past(carry_i); endproperty
  a_carry: assert property (p_carry) else $error("carry update lost");
  property p_arith;
    arith_we_i |=> flags_o[6] == $past(half_carry_i) && flags_o[2] == $past(arith_oflow_i);
  endproperty
  a_arith: assert property (p_arith) else $error("half carry or overflow lost");
  // pre-increment on push, post-decrement on pop
  property p_push; stack_push_i && !stack_pop_i |=> stack_top_o == $past(stack_top_o) + 8'h01;
  endproperty
  a_push: assert property (p_push) else $error("push did not move top up");
  property p_pop; stack_pop_i && !stack_push_i |=> stack_top_o == $past(stack_top_o) - 8'h01;
  endproperty
  a_pop: assert property (p_pop) else $error("pop did not move top down");
  property p_bank; work_reg_addr_o == {3'h0, flags_o[4:3], work_reg_i}; endproperty
  a_bank: assert property (p_bank) else $error("working register address off");
  property p_refuse;
    internal_scratch_ram_refused_o == ((internal_scratch_ram_wr_i || internal_scratch_ram_rd_i) && internal_scratch_ram_addr_i[7] && !internal_scratch_ram_indirect_i);
  endproperty
  a_refuse: assert property (p_refuse) else $error("upper ram refusal off");
  property p_xhit; xram_hit_o == (xram_addr_i >= 16'h8000 && xram_addr_i <= 16'h87ff);
  endproperty
  a_xhit: assert property (p_xhit) else $error("external ram decode off");
  // write to choice in the same cycle could swap pointers, so excluded
  property p_pinc;
    ptr_inc_i && !ptr_load_i && !sfr_wr_i |=> ptr_addr_o == $past(ptr_addr_o) + 16'h0001;
  endproperty
  a_pinc: assert property (p_pinc) else $error("pointer increment off");
  property p_idle; !sfr_rd_i |=> sfr_rdata_o == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("read data outside its cycle");
  // main scenarios seen
  c_push: cover property (stack_push_i && !stack_pop_i);
  c_refuse: cover property (internal_scratch_ram_refused_o);
  c_xhit: cover property (xram_hit_o);
endmodule // mcsr_core_regs_props
bind mcsr_core_regs mcsr_core_regs_props u_props (.*);

// ==== mcsr_core_regs_tb.sv ====
// self-checking bench for the core register block
`timescale 1ns/1ns
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module mcsr_core_regs_tb;
  logic core_clk_i = 1'b0, reset_i = 1'b1; // clock and reset
  logic sfr_wr_i = 1'b0, sfr_rd_i = 1'b0, acc_we_i = 1'b0, carry_we_i = 1'b0, carry_i = 1'b0;
  logic arith_we_i = 1'b0, half_carry_i = 1'b0, arith_oflow_i = 1'b0, helper_we_i = 1'b0;
  logic stack_push_i = 1'b0, stack_pop_i = 1'b0, ptr_load_i = 1'b0, ptr_inc_i = 1'b0;
  logic internal_scratch_ram_indirect_i = 1'b0, internal_scratch_ram_wr_i = 1'b0, internal_scratch_ram_rd_i = 1'b0, xram_wr_i = 1'b0;
  logic xram_rd_i = 1'b0;
  logic [7:0] sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00, acc_i = 8'h00, helper_i = 8'h00;
  logic [7:0] internal_scratch_ram_addr_i = 8'h00, internal_scratch_ram_wdata_i = 8'h00, xram_wdata_i = 8'h00;
  logic [15:0] ptr_load_value_i = 16'h0000, xram_addr_i = 16'h0000;
  logic [2:0] work_reg_i = 3'h5;
  wire [7:0] sfr_rdata_o, internal_scratch_ram_rdata_o, xram_rdata_o, acc_o, helper_o, flags_o, stack_top_o;
  wire [7:0] work_reg_addr_o;
  wire [15:0] ptr_addr_o;
  wire [2:0] prog_wait_states_o, external_space_ram_stretch_o;
  wire internal_scratch_ram_refused_o, xram_hit_o;
  int n_mismatch = 0, checks_done = 0;
  logic r_flag; // refusal or hit seen during an access
  logic [7:0] r_data; // ram read data
  // rows: address, write data, expected read back
  // timing rows write only the legal codes; spare bits 7 and 3 must drop
  logic [23:0] rows [13] = '{24'h815a5a, 24'h821111, 24'h832222, 24'h843333, 24'h843333,
    24'h854444, 24'h8e8901, 24'h8e0101, 24'hd0fffe, 24'hd00000, 24'hf0a5a5, 24'h409900, 24'h92ff01};
  // reset values, address beside expected value
  logic [15:0] rst_rows [10] = '{16'h8107, 16'h8200, 16'h8300, 16'h8400, 16'h8500, 16'h8e01,
    16'h9200, 16'hd000, 16'he000, 16'hf000};
  mcsr_core_regs u_dut (.*);
  initial begin
    forever #10 core_clk_i = ~core_clk_i;
  end
  // hang guard, well above the run length
  initial begin
    repeat (5000) @(posedge core_clk_i);
    n_mismatch++;
    wrap_up();
  end
  task wrap_up();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // one-cycle register write
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    sfr_addr_i <= a; sfr_wdata_i <= d; sfr_wr_i <= 1'b1;
    @(posedge core_clk_i);
    sfr_wr_i <= 1'b0;
    @(negedge core_clk_i);
  endtask
  // read; data stands only in the following cycle
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk_i);
    sfr_addr_i <= a; sfr_rd_i <= 1'b1;
    @(posedge core_clk_i);
    sfr_rd_i <= 1'b0;
    @(negedge core_clk_i);
    `CHK("sfr read", e, sfr_rdata_o)
  endtask
  task internal_scratch_ram(input logic [7:0] a, input logic ind, input logic w, input logic [7:0] d);
    @(posedge core_clk_i);
    internal_scratch_ram_addr_i <= a; internal_scratch_ram_indirect_i <= ind; internal_scratch_ram_wdata_i <= d;
    internal_scratch_ram_wr_i <= w; internal_scratch_ram_rd_i <= !w;
    @(negedge core_clk_i) r_flag = internal_scratch_ram_refused_o;
    @(posedge core_clk_i);
    internal_scratch_ram_wr_i <= 1'b0; internal_scratch_ram_rd_i <= 1'b0;
    @(negedge core_clk_i) r_data = internal_scratch_ram_rdata_o;
  endtask
  task xram(input logic [15:0] a, input logic w, input logic [7:0] d);
    @(posedge core_clk_i);
    xram_addr_i <= a; xram_wdata_i <= d; xram_wr_i <= w; xram_rd_i <= !w;
    @(negedge core_clk_i) r_flag = xram_hit_o;
    @(posedge core_clk_i);
    xram_wr_i <= 1'b0; xram_rd_i <= 1'b0;
    @(negedge core_clk_i) r_data = xram_rdata_o;
  endtask
  initial begin
    repeat (4) @(posedge core_clk_i);
    reset_i <= 1'b0;
    // write then read back each row; spare bits and parity drop
    foreach (rows[i]) begin
      wr(rows[i][23:16], rows[i][15:8]);
      rd(rows[i][23:16], rows[i][7:0]);
    end
    `CHK("pointer one", 16'h4433, ptr_addr_o)
    // second reset in mid-run
    @(posedge core_clk_i) reset_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    reset_i <= 1'b0;
    foreach (rst_rows[i]) rd(rst_rows[i][15:8], rst_rows[i][7:0]);
    `CHK("stretch", 3'h1, external_space_ram_stretch_o)
    `CHK("wait", 3'h0, prog_wait_states_o)
    // every bank choice
    for (int b = 0; b < 4; b++) begin
      wr(8'hd0, 8'(b << 3));
      `CHK("bank reg", 8'(b * 8 + 5), work_reg_addr_o)
    end
    // accumulator, flag, helper and stack updates in one cycle, user flags kept
    wr(8'hd0, 8'h22);
    @(posedge core_clk_i);
    acc_we_i <= 1'b1; acc_i <= 8'h07; carry_we_i <= 1'b1; carry_i <= 1'b1;
    arith_we_i <= 1'b1; half_carry_i <= 1'b1; arith_oflow_i <= 1'b1;
    helper_we_i <= 1'b1; helper_i <= 8'h9c; stack_push_i <= 1'b1;
    sfr_addr_i <= 8'hf0; sfr_wdata_i <= 8'h11; sfr_wr_i <= 1'b1; // software write must lose
    @(posedge core_clk_i);
    acc_we_i <= 1'b0; carry_we_i <= 1'b0; arith_we_i <= 1'b0; helper_we_i <= 1'b0;
    sfr_wr_i <= 1'b0;
    stack_pop_i <= 1'b1; // push with pop: no move
    @(posedge core_clk_i);
    stack_push_i <= 1'b0; // pop alone next
    @(posedge core_clk_i);
    stack_pop_i <= 1'b0;
    @(negedge core_clk_i);
    `CHK("flags", 8'he7, flags_o)
    `CHK("helper", 8'h9c, helper_o)
    `CHK("stack", 8'h07, stack_top_o)
    `CHK("acc", 8'h07, acc_o)
    rd(8'he0, 8'h07);
    // whole-pointer load and increment across the byte boundary
    @(posedge core_clk_i);
    ptr_load_i <= 1'b1; ptr_load_value_i <= 16'h12ff;
    @(posedge core_clk_i);
    ptr_load_i <= 1'b0; ptr_inc_i <= 1'b1;
    @(posedge core_clk_i);
    ptr_inc_i <= 1'b0;
    rd(8'h82, 8'h00);
    rd(8'h83, 8'h13);
    wr(8'h92, 8'h01);
    `CHK("pointer swap", 16'h0000, ptr_addr_o)
    // upper internal ram only through indirect access
    internal_scratch_ram(8'h90, 1'b1, 1'b1, 8'h3c);
    `CHK("indirect ok", 1'b0, r_flag)
    internal_scratch_ram(8'h90, 1'b0, 1'b1, 8'hc3);
    `CHK("direct refused", 1'b1, r_flag)
    internal_scratch_ram(8'h90, 1'b1, 1'b0, 8'h00);
    `CHK("upper ram", 8'h3c, r_data)
    internal_scratch_ram(8'h10, 1'b0, 1'b1, 8'h5a);
    internal_scratch_ram(8'h10, 1'b0, 1'b0, 8'h00);
    `CHK("lower ram", 8'h5a, r_data)
    // external ram edges of the decoded range
    xram(16'h87ff, 1'b1, 8'h5e);
    xram(16'h8800, 1'b1, 8'h11);
    `CHK("past end", 1'b0, r_flag)
    xram(16'h87ff, 1'b0, 8'h00);
    `CHK("last byte", 8'h5e, r_data)
    xram(16'h7fff, 1'b0, 8'h00);
    `CHK("below base", 8'h00, r_data)
    wrap_up();
  end
endmodule // mcsr_core_regs_tb
